// ==== src/tacp_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tacp_control #(
    parameter int MULT_START_CYCLES = tacp_pkg::MULT_START_DEF,
    parameter int POR_CYCLES        = tacp_pkg::POR_DELAY
) (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_supply_warn,
    input  wire logic       i_supply_low,
    input  wire logic       i_serial_start,
    output logic      [7:0] o_rdata,
    output logic            o_sys_reset,
    output logic            o_power_warn_irq,
    output logic            o_machine_tick,
    output logic            o_mult_on,
    output logic            o_mult_x4,
    output logic            o_bandgap_on,
    output logic            o_timer_tick12,
    output logic      [7:0] o_address_control,
    output logic      [7:0] o_program_size,
    output logic      [7:0] o_flash_control
);
    import tacp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Merge a write under a protection mask
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic open_w);
        merge = open_w ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] warn_s;
    logic [1:0] low_s;
    logic [1:0] start_s;
    logic       start_d;

    always_ff @(posedge i_mclk) begin
        warn_s  <= {warn_s[0], i_supply_warn};
        low_s   <= {low_s[0], i_supply_low};
        start_s <= {start_s[0], i_serial_start};
        start_d <= start_s[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-on and brownout reset
    logic [16:0] por_cnt;
    logic [16:0] next_por_cnt;
    logic        por_done;
    logic        next_por_done;
    logic        sys_rst;

    always_comb begin
        next_por_cnt  = por_cnt;
        next_por_done = por_done;
        if (low_s[1]) begin
            next_por_cnt  = '0;
            next_por_done = 1'b0;
        end else if (!por_done) begin
            if (por_cnt == 17'(POR_CYCLES - 1))
                next_por_done = 1'b1;
            else
                next_por_cnt = por_cnt + 17'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            por_cnt  <= '0;
            por_done <= 1'b0;
        end else begin
            por_cnt  <= next_por_cnt;
            por_done <= next_por_done;
        end
    end

    assign sys_rst = i_reset | ~por_done;

    ////////////////////////////////////////////////////////////////////////////
    // Machine-cycle enable: divide by 1 or by 1024
    logic [9:0] slow_cnt;
    logic [9:0] next_slow_cnt;
    logic [1:0] clk_div;
    logic       tick;

    always_comb begin
        next_slow_cnt = slow_cnt;
        if (clk_div == CD_SLOW)
            next_slow_cnt = (slow_cnt == SLOW_LAST) ? 10'h0 : slow_cnt + 10'h1;
        else
            next_slow_cnt = 10'h0;
    end
    assign tick = (clk_div != CD_SLOW) || (slow_cnt == SLOW_LAST);

    always_ff @(posedge i_mclk) begin
        if (sys_rst)
            slow_cnt <= '0;
        else
            slow_cnt <= next_slow_cnt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timed-access key sequencer
    tacp_key_t  key_st;
    tacp_key_t  next_key_st;
    logic [1:0] key_cnt;
    logic [1:0] next_key_cnt;
    logic       key_wr;
    logic       unlocked;

    assign key_wr   = i_wr && (i_addr == ADDR_TIMED_KEY);
    assign unlocked = (key_st == TACP_OPEN);

    always_comb begin
        next_key_st  = key_st;
        next_key_cnt = key_cnt;
        if (tick && key_st != TACP_LOCKED)
            next_key_cnt = key_cnt + 2'h1;
        case (key_st)
            TACP_LOCKED: begin
                next_key_cnt = '0;
            end
            TACP_ARMED: begin
                if (tick && key_cnt == UNLOCK_TOP - 2'h1)
                    next_key_st = TACP_LOCKED;
            end
            TACP_OPEN: begin
                if (tick && key_cnt == UNLOCK_TOP - 2'h1)
                    next_key_st = TACP_LOCKED;
            end
            default: begin
                next_key_st = TACP_LOCKED;
            end
        endcase
        if (key_wr) begin
            next_key_cnt = '0;
            if (i_wdata == KEY_FIRST)
                next_key_st = TACP_ARMED;
            else if (i_wdata == KEY_SECOND && key_st == TACP_ARMED)
                next_key_st = TACP_OPEN;
            else
                next_key_st = TACP_LOCKED;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (sys_rst) begin
            key_st  <= TACP_LOCKED;
            key_cnt <= '0;
        end else begin
            key_st  <= next_key_st;
            key_cnt <= next_key_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] wdog;
    logic [7:0] extended_interrupt_flags;
    logic [7:0] power_management_register;
    logic [7:0] address_control_register;
    logic [7:0] rsize;
    logic [7:0] fctl;
    logic [7:0] extended_interrupt_enable;
    logic [7:0] power_control;
    logic [7:0] tclk;
    logic [7:0] next_wdog;
    logic [7:0] next_extended_interrupt_flags;
    logic [7:0] next_pmr;
    logic [7:0] next_address_control_register;
    logic [7:0] next_rsize;
    logic [7:0] next_fctl;
    logic [7:0] next_eie;
    logic [7:0] next_power_control;
    logic [7:0] next_tclk;
    logic       ready;
    logic       next_ready;
    logic [16:0] mcnt;
    logic [16:0] next_mcnt;
    logic       warn_d;
    logic       por_flag_set;

    assign clk_div = power_management_register[CLK_DIV_LSB +: 2];

    always_comb begin
        next_wdog  = wdog;
        next_extended_interrupt_flags  = extended_interrupt_flags;
        next_pmr   = power_management_register;
        next_address_control_register  = address_control_register;
        next_rsize = rsize;
        next_fctl  = fctl;
        next_eie   = extended_interrupt_enable;
        next_power_control  = power_control;
        next_tclk  = tclk;
        next_ready = ready;
        next_mcnt  = mcnt;
        if (i_wr) begin
            case (i_addr)
                ADDR_WDOG_POWER:     next_wdog  = merge(wdog, i_wdata, PROTECT_WDOG, unlocked);
                ADDR_EXT_INT_FLAGS:  next_extended_interrupt_flags  = merge(extended_interrupt_flags, i_wdata, PROTECT_EXTENDED_INTERRUPT_FLAGS, unlocked);
                ADDR_ADDRESS_CTRL:   next_address_control_register  = merge(address_control_register, i_wdata, PROTECT_ADDRESS_CONTROL_REGISTER, unlocked);
                ADDR_PROG_SIZE:      next_rsize = merge(rsize, i_wdata, PROTECT_SIZE, unlocked);
                ADDR_FLASH_CTRL:     next_fctl  = merge(fctl, i_wdata, PROTECT_FLASH, unlocked);
                ADDR_EXT_INT_ENABLE: next_eie   = i_wdata;
                ADDR_POWER_CONTROL:  next_power_control  = i_wdata;
                ADDR_TIMER_CLOCK:    next_tclk  = i_wdata;
                ADDR_POWER_MGMT: begin
                    next_pmr[SWITCHBACK_BIT] = i_wdata[SWITCHBACK_BIT];
                    next_pmr[RING_BIT]       = i_wdata[RING_BIT];
                    next_pmr[STOP_BIT]       = i_wdata[STOP_BIT];
                    if (!power_management_register[MULT_EN_BIT])
                        next_pmr[MULT_RATIO_BIT] = i_wdata[MULT_RATIO_BIT];
                    if ((clk_div == CD_DIV1 || clk_div == CD_RSVD) && !power_management_register[RING_BIT])
                        next_pmr[MULT_EN_BIT] = i_wdata[MULT_EN_BIT];
                    if (!(i_wdata[CLK_DIV_LSB +: 2] == CD_MULT && !ready))
                        next_pmr[CLK_DIV_LSB +: 2] = i_wdata[CLK_DIV_LSB +: 2];
                end
                default: ;
            endcase
        end
        // Multiplier startup count
        if (!power_management_register[MULT_EN_BIT] && next_pmr[MULT_EN_BIT]) begin
            next_ready = 1'b0;
            next_mcnt  = '0;
        end else if (!next_pmr[MULT_EN_BIT]) begin
            next_ready = 1'b0;
        end else if (!ready) begin
            if (mcnt == 17'(MULT_START_CYCLES - 1))
                next_ready = 1'b1;
            else
                next_mcnt = mcnt + 17'h1;
        end
        // Start-bit switchback
        if (clk_div == CD_SLOW && power_management_register[SWITCHBACK_BIT] && start_s[1] && !start_d)
            next_pmr[CLK_DIV_LSB +: 2] = CD_DIV1;
        // Warning flag: hardware set wins over software clear
        if (warn_s[1] && !warn_d)
            next_wdog[PWR_WARN_BIT] = 1'b1;
        if (por_flag_set)
            next_wdog[POWER_ON_BIT] = 1'b1;
    end

    always_ff @(posedge i_mclk) begin
        warn_d <= warn_s[1];
        if (i_reset)
            por_flag_set <= 1'b0;
        else
            por_flag_set <= ~por_done & next_por_done;
        if (sys_rst) begin
            wdog  <= {1'b0, wdog[POWER_ON_BIT], 6'h0};
            extended_interrupt_flags  <= RST_ZERO;
            power_management_register   <= RST_POWER_MGMT;
            address_control_register  <= RST_ZERO;
            rsize <= RST_ZERO;
            fctl  <= RST_ZERO;
            extended_interrupt_enable   <= RST_ZERO;
            power_control  <= RST_ZERO;
            tclk  <= RST_ZERO;
            ready <= 1'b0;
            mcnt  <= '0;
        end else begin
            wdog  <= next_wdog;
            extended_interrupt_flags  <= next_extended_interrupt_flags;
            power_management_register   <= next_pmr;
            address_control_register  <= next_address_control_register;
            rsize <= next_rsize;
            fctl  <= next_fctl;
            extended_interrupt_enable   <= next_eie;
            power_control  <= next_power_control;
            tclk  <= next_tclk;
            ready <= next_ready;
            mcnt  <= next_mcnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divide-by-12 baud tick
    logic [3:0] b12;
    logic [3:0] next_b12;
    logic       next_t12;

    always_comb begin
        next_b12 = b12;
        next_t12 = 1'b0;
        if (tclk[1:0] == 2'h0) begin
            if (b12 == 4'(BAUD_DIVIDE - 1)) begin
                next_b12 = 4'h0;
                next_t12 = 1'b1;
            end else begin
                next_b12 = b12 + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and outputs
    logic [7:0] next_rdata;

    always_comb begin
        case (i_addr)
            ADDR_WDOG_POWER:     next_rdata = wdog;
            ADDR_EXT_INT_FLAGS:  next_rdata = extended_interrupt_flags;
            ADDR_POWER_MGMT:     next_rdata = power_management_register;
            ADDR_ADDRESS_CTRL:   next_rdata = address_control_register;
            ADDR_PROG_SIZE:      next_rdata = rsize;
            ADDR_FLASH_CTRL:     next_rdata = fctl;
            ADDR_EXT_INT_ENABLE: next_rdata = extended_interrupt_enable;
            ADDR_POWER_CONTROL:  next_rdata = power_control;
            ADDR_TIMER_CLOCK:    next_rdata = tclk;
            ADDR_STATUS:         next_rdata = {4'h0, ready, 3'h0};
            default:             next_rdata = 8'h00;
        endcase
        if (!i_rd)
            next_rdata = 8'h00;
    end

    always_ff @(posedge i_mclk) begin
        o_rdata           <= next_rdata;
        o_sys_reset       <= sys_rst;
        o_machine_tick    <= tick & ~sys_rst;
        o_power_warn_irq  <= wdog[PWR_WARN_BIT] & wdog[PWR_WARN_EN_BIT];
        o_mult_on         <= power_management_register[MULT_EN_BIT];
        o_mult_x4         <= power_management_register[MULT_RATIO_BIT];
        o_bandgap_on      <= ~power_management_register[STOP_BIT] | extended_interrupt_flags[BANDGAP_BIT];
        o_address_control <= address_control_register;
        o_program_size    <= rsize;
        o_flash_control   <= fctl;
        if (sys_rst) begin
            b12            <= '0;
            o_timer_tick12 <= 1'b0;
        end else begin
            b12            <= next_b12;
            o_timer_tick12 <= next_t12;
        end
    end

endmodule
`default_nettype wire

// ==== src/tacp_pkg.sv ====
package tacp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h87;
    localparam logic [7:0] ADDR_EXT_INT_FLAGS  = 8'h91;
    localparam logic [7:0] ADDR_TIMED_KEY      = 8'hc7;
    localparam logic [7:0] ADDR_WDOG_POWER     = 8'hd8;
    localparam logic [7:0] ADDR_EXT_INT_ENABLE = 8'he8;
    localparam logic [7:0] ADDR_POWER_MGMT     = 8'hc4;
    localparam logic [7:0] ADDR_ADDRESS_CTRL   = 8'h9d;
    localparam logic [7:0] ADDR_PROG_SIZE      = 8'hc2;
    localparam logic [7:0] ADDR_FLASH_CTRL     = 8'hd5;
    localparam logic [7:0] ADDR_STATUS         = 8'hc5;
    localparam logic [7:0] ADDR_TIMER_CLOCK    = 8'h8e;

    ////////////////////////////////////////////////////////////////////////////
    // Key values
    localparam logic [7:0] KEY_FIRST  = 8'haa;
    localparam logic [7:0] KEY_SECOND = 8'h55;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int WD_RESTART_BIT  = 0;
    localparam int WD_RESET_EN_BIT = 1;
    localparam int WD_RESET_FLAG   = 2;
    localparam int WD_IRQ_FLAG_BIT = 3;
    localparam int PWR_WARN_BIT    = 4;
    localparam int PWR_WARN_EN_BIT = 5;
    localparam int POWER_ON_BIT    = 6;
    localparam int BANDGAP_BIT     = 0;
    localparam int STOP_BIT        = 1;
    localparam int RING_BIT        = 2;
    localparam int MULT_RATIO_BIT  = 3;
    localparam int MULT_EN_BIT     = 4;
    localparam int SWITCHBACK_BIT  = 5;
    localparam int CLK_DIV_LSB     = 6;
    localparam int MULT_READY_BIT  = 3;
    localparam logic [7:0] PROTECT_WDOG  = 8'h4b;
    localparam logic [7:0] PROTECT_EXTENDED_INTERRUPT_FLAGS  = 8'h01;
    localparam logic [7:0] PROTECT_ADDRESS_CONTROL_REGISTER  = 8'he0;
    localparam logic [7:0] PROTECT_SIZE  = 8'h0f;
    localparam logic [7:0] PROTECT_FLASH = 8'h0f;

    ////////////////////////////////////////////////////////////////////////////
    // Clock divide codes
    localparam logic [1:0] CD_MULT = 2'h0;
    localparam logic [1:0] CD_RSVD = 2'h1;
    localparam logic [1:0] CD_DIV1 = 2'h2;
    localparam logic [1:0] CD_SLOW = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_POWER_MGMT = 8'h80;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int UNLOCK_CYCLES   = 3;
    localparam int SLOW_DIVIDE     = 1024;
    localparam int BAUD_DIVIDE     = 12;
    localparam int POR_DELAY       = 65536;
    localparam int MULT_START_DEF  = 65536;
    localparam logic [9:0]  SLOW_LAST  = 10'(SLOW_DIVIDE - 1);
    localparam logic [1:0]  UNLOCK_TOP = 2'(UNLOCK_CYCLES);
    localparam logic [16:0] POR_TOP    = 17'(POR_DELAY);

    typedef enum logic [1:0] {
        TACP_LOCKED  = 2'b00,
        TACP_ARMED   = 2'b01,
        TACP_OPEN    = 2'b11
    } tacp_key_t;

endpackage

// ==== testbench/tacp_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module tacp_props #(
    parameter int POR_CYCLES = 16
) (
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_supply_warn,
    input wire logic       i_supply_low,
    input wire logic       i_serial_start,
    input wire logic [7:0] o_rdata,
    input wire logic       o_sys_reset,
    input wire logic       o_power_warn_irq,
    input wire logic       o_machine_tick,
    input wire logic       o_mult_on,
    input wire logic       o_mult_x4,
    input wire logic       o_bandgap_on,
    input wire logic       o_timer_tick12,
    input wire logic [7:0] o_address_control,
    input wire logic [7:0] o_program_size,
    input wire logic [7:0] o_flash_control
);
    import tacp_pkg::*;
    logic [16:0] cnt;
    logic [16:0] next_cnt;
    logic [3:0]  low_hist;
    logic [3:0]  next_low_hist;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset || o_sys_reset);

    ////////////////////////////////////////////////////////////////////////////
    // Cycles since reset or low supply, and recent low supply history
    always_comb begin
        next_cnt = (i_reset || i_supply_low) ? 17'h0 : (cnt[16] ? cnt : cnt + 17'h1);
        next_low_hist = {low_hist[2:0], i_supply_low};
    end
    always_ff @(posedge i_mclk) begin
        cnt <= next_cnt;
        low_hist <= next_low_hist;
    end

    ////////////////////////////////////////////////////////////////////////////
    // An output changes only after a write to its register or a brownout
    property p_by_write(logic sig, logic [7:0] a);
        $changed(sig) |-> $past(i_wr && i_addr == a) || $past(i_wr && i_addr == a, 2) || (|low_hist);
    endproperty

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
    a_reset_hold: assert property (disable iff (1'b0) i_reset |=> o_sys_reset) else $error("reset not held");
    a_brownout_reset: assert property (disable iff (i_reset) i_supply_low [*3] |-> ##[0:3] o_sys_reset)
        else $error("brownout gave no reset");
    a_por_delay: assert property (disable iff (i_reset) $fell(o_sys_reset) |-> cnt >= 17'(POR_CYCLES))
        else $error("reset released early");
    a_por_release: assert property (disable iff (i_reset) cnt > 17'(POR_CYCLES + 8) |-> !o_sys_reset)
        else $error("reset released late");
    a_mult_reset: assert property (disable iff (1'b0) i_reset ##1 i_reset |=> !o_mult_on)
        else $error("multiplier on in reset");
    a_tick12_gap: assert property (o_timer_tick12 |=> !o_timer_tick12 [*8]) else $error("timer tick too close");
    a_warn_sticky: assert property ($fell(o_power_warn_irq) |-> $past(i_wr && i_addr == ADDR_WDOG_POWER)
        || $past(i_wr && i_addr == ADDR_WDOG_POWER, 2)) else $error("warning cleared by hardware");
    a_bandgap_off: assert property ($fell(o_bandgap_on) |-> $past(i_wr) || $past(i_wr, 2))
        else $error("bandgap off without write");
    a_mult_write: assert property (p_by_write(o_mult_on, ADDR_POWER_MGMT)) else $error("mult enable moved");
    a_ratio_write: assert property (p_by_write(o_mult_x4, ADDR_POWER_MGMT)) else $error("ratio moved");
    a_size_write: assert property (p_by_write(o_program_size[0], ADDR_PROG_SIZE)) else $error("size moved");

    c_release: cover property (disable iff (i_reset) $fell(o_sys_reset));
    c_warn: cover property ($rose(o_power_warn_irq));
    c_mult: cover property ($rose(o_mult_on));
endmodule
bind tacp_control tacp_props #(.POR_CYCLES(POR_CYCLES)) u_props (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_supply_warn(i_supply_warn), .i_supply_low(i_supply_low), .i_serial_start(i_serial_start),
    .o_rdata(o_rdata), .o_sys_reset(o_sys_reset), .o_power_warn_irq(o_power_warn_irq),
    .o_machine_tick(o_machine_tick), .o_mult_on(o_mult_on), .o_mult_x4(o_mult_x4), .o_bandgap_on(o_bandgap_on),
    .o_timer_tick12(o_timer_tick12), .o_address_control(o_address_control), .o_program_size(o_program_size),
    .o_flash_control(o_flash_control));
`default_nettype wire

// ==== testbench/timed_access_clock_power_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module timed_access_clock_power_control_tb_top;
    import tacp_pkg::*;
    localparam int POR_N = 16;
    localparam int MULT_N = 8;
    logic        i_mclk, i_reset, i_wr, i_rd, i_supply_warn, i_supply_low, i_serial_start;
    logic [7:0]  i_addr, i_wdata, o_rdata, o_address_control, o_program_size, o_flash_control, rv, ef, es;
    logic        o_sys_reset, o_power_warn_irq, o_machine_tick, o_mult_on, o_mult_x4, o_bandgap_on, o_timer_tick12;
    int          fails, checks_done, n_mt, n_tt;
    logic [31:0] seed;

    tacp_control #(.MULT_START_CYCLES(MULT_N), .POR_CYCLES(POR_N)) u_dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_supply_warn(i_supply_warn), .i_supply_low(i_supply_low), .i_serial_start(i_serial_start),
        .o_rdata(o_rdata), .o_sys_reset(o_sys_reset), .o_power_warn_irq(o_power_warn_irq),
        .o_machine_tick(o_machine_tick), .o_mult_on(o_mult_on), .o_mult_x4(o_mult_x4),
        .o_bandgap_on(o_bandgap_on), .o_timer_tick12(o_timer_tick12), .o_address_control(o_address_control),
        .o_program_size(o_program_size), .o_flash_control(o_flash_control));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic key(input logic [7:0] d);
        wr(ADDR_TIMED_KEY, d);
    endtask
    // Key pair sent back to back, nothing may slip in between
    task automatic unlock;
        key(KEY_FIRST);
        key(KEY_SECOND);
    endtask
    task automatic idle(input int n);
        @(posedge i_mclk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic count(input int n);
        n_mt = 0;
        n_tt = 0;
        repeat (n) begin
            @(posedge i_mclk);
            #1;
            n_mt += (o_machine_tick === 1'b1);
            n_tt += (o_timer_tick12 === 1'b1);
        end
    endtask
    task automatic wait_run;
        for (int k = 0; k < 200 && o_sys_reset !== 1'b0; k++) @(posedge i_mclk);
        if (o_sys_reset !== 1'b0) begin
            fails++;
            print_verdict();
        end else begin
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    initial begin
        #400000;
        fails++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_reset, i_wr, i_rd, i_supply_warn, i_supply_low, i_serial_start} = 6'b100000;
        {i_addr, i_wdata} = 16'h0;
        {fails, checks_done} = 0;
        seed = 32'ha0eb;
        ef = RST_ZERO;
        es = RST_ZERO;
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        wait_run();
        rd(ADDR_POWER_MGMT);
        chk(rv, RST_POWER_MGMT);
        rd(ADDR_WDOG_POWER);
        chk(8'(rv[POWER_ON_BIT]), 8'h1);
        rd(8'h00);
        chk(rv, 8'h00);
        count(20);
        chk(8'(n_mt), 8'd20);
        // Locked, open, late, wrong key, late key
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            case (i % 5)
                1: unlock();
                2: begin
                    unlock();
                    idle(4);
                end
                3: begin
                    key(KEY_FIRST);
                    key(8'h12);
                    key(KEY_SECOND);
                end
                4: begin
                    key(KEY_FIRST);
                    idle(4);
                    key(KEY_SECOND);
                end
                default: ;
            endcase
            wr(ADDR_FLASH_CTRL, seed[7:0]);
            wr(ADDR_PROG_SIZE, seed[15:8]);
            idle(2);
            if (i % 5 == 1) begin
                ef = {4'h0, seed[3:0]};
                es = {4'h0, seed[11:8]};
            end
            chk(o_flash_control & 8'h0f, ef);
            chk(o_program_size & 8'h0f, es);
        end
        // Power-on flag survives a locked clear, then an open clear removes it
        wr(ADDR_WDOG_POWER, 8'h00);
        rd(ADDR_WDOG_POWER);
        chk(8'(rv[POWER_ON_BIT]), 8'h1);
        unlock();
        wr(ADDR_WDOG_POWER, 8'h00);
        rd(ADDR_WDOG_POWER);
        chk(8'(rv[POWER_ON_BIT]), 8'h0);
        // Slow and reserved divide codes
        wr(ADDR_POWER_MGMT, 8'hc0);
        idle(4);
        count(2048);
        chk(8'(n_mt), 8'd2);
        wr(ADDR_POWER_MGMT, 8'h40);
        idle(2);
        count(20);
        chk(8'(n_mt), 8'd20);
        // Start bit with and without switchback
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_POWER_MGMT, s ? 8'he0 : 8'hc0);
            idle(2);
            i_serial_start <= 1'b1;
            idle(6);
            i_serial_start <= 1'b0;
            rd(ADDR_POWER_MGMT);
            chk(rv & 8'hc0, s ? 8'h80 : 8'hc0);
        end
        // Multiplier start-up, ratio lock and enable lock
        wr(ADDR_POWER_MGMT, 8'h98);
        wr(ADDR_POWER_MGMT, 8'h18);
        idle(1);
        chk({6'h0, o_mult_on, o_mult_x4}, 8'h03);
        rd(ADDR_POWER_MGMT);
        chk(rv & 8'hc0, 8'h80);
        rd(ADDR_STATUS);
        chk(rv & 8'h08, 8'h00);
        idle(MULT_N + 8);
        rd(ADDR_STATUS);
        chk(rv & 8'h08, 8'h08);
        wr(ADDR_POWER_MGMT, 8'h10);
        idle(2);
        count(20);
        chk({6'h0, o_mult_x4, 1'b0} | 8'(n_mt), 8'd22);
        wr(ADDR_POWER_MGMT, 8'h00);
        idle(2);
        chk(8'(o_mult_on), 8'h1);
        wr(ADDR_POWER_MGMT, 8'h80);
        wr(ADDR_POWER_MGMT, 8'h84);
        wr(ADDR_POWER_MGMT, 8'h94);
        idle(2);
        chk(8'(o_mult_on), 8'h0);
        // Timer baud tick on and off
        wr(ADDR_TIMER_CLOCK, 8'h00);
        idle(14);
        count(48);
        chk(8'(n_tt), 8'd4);
        wr(ADDR_TIMER_CLOCK, 8'h01);
        idle(2);
        count(48);
        chk(8'(n_tt), 8'd0);
        // Supply warning sets a sticky flag
        wr(ADDR_WDOG_POWER, 8'h20);
        idle(1);
        i_supply_warn <= 1'b1;
        idle(6);
        chk(8'(o_power_warn_irq), 8'h1);
        i_supply_warn <= 1'b0;
        idle(6);
        rd(ADDR_WDOG_POWER);
        chk(rv & 8'h30, 8'h30);
        wr(ADDR_WDOG_POWER, 8'h20);
        idle(3);
        chk(8'(o_power_warn_irq), 8'h0);
        // Stop request with and without keep-alive
        wr(ADDR_POWER_MGMT, 8'h82);
        idle(2);
        chk(8'(o_bandgap_on), 8'h0);
        unlock();
        wr(ADDR_EXT_INT_FLAGS, 8'h01);
        wr(ADDR_ADDRESS_CTRL, 8'he5);
        idle(2);
        chk(8'(o_bandgap_on), 8'h1);
        chk(o_address_control, 8'he5);
        wr(ADDR_ADDRESS_CTRL, 8'h00);
        idle(2);
        chk(o_address_control, 8'he0);
        // Brownout and power-up delay
        wr(ADDR_POWER_MGMT, 8'hc0);
        idle(1);
        i_supply_low <= 1'b1;
        idle(4);
        chk(8'(o_sys_reset), 8'h1);
        i_supply_low <= 1'b0;
        idle(POR_N - 4);
        chk(8'(o_sys_reset), 8'h1);
        wait_run();
        rd(ADDR_POWER_MGMT);
        chk(rv, RST_POWER_MGMT);
        print_verdict();
    end
endmodule
`default_nettype wire
